// ### pkg/phy_dsp_tuning_defines.vh
// register offsets, reset values and field positions of the dsp tuning bank
// assumes wishbone byte addressing: byte address = 4 * register index
`ifndef PHY_DSP_TUNING_DEFINES_VH
`define PHY_DSP_TUNING_DEFINES_VH

// register indices
`define IDX_DSP_CONFIG_ONE        9'h101
`define IDX_FILTER_CONFIG_ONE     9'h106
`define IDX_FILTER_CONFIG_TWO     9'h107
`define IDX_DSP_CONFIG_TWO        9'h10f
`define IDX_DSP_CONFIG_THREE      9'h111
`define IDX_FEEDBACK_EQ_CONTROL   9'h114
`define IDX_GAIN_BW_CONTROL       9'h116
`define IDX_RECOVERY_ERR_THR      9'h121
`define IDX_TIMING_LOOP_ERR_THR   9'h122
`define IDX_LINKUP_ERR_THR        9'h123
`define IDX_EQ_TRAINING_TIMERS    9'h126
`define IDX_DSP_CONFIG_FOUR       9'h129

// reset values
`define RST_DSP_CONFIG_ONE        16'h2000
`define RST_FILTER_CONFIG_ONE     16'hb0bb
`define RST_FILTER_CONFIG_TWO     16'h0605
`define RST_DSP_CONFIG_TWO        16'h0300
`define RST_DSP_CONFIG_THREE      16'h6003
`define RST_FEEDBACK_EQ_CONTROL   16'h400a
`define RST_GAIN_BW_CONTROL       16'h014a
`define RST_RECOVERY_ERR_THR      16'h199a
`define RST_TIMING_LOOP_ERR_THR   16'h1027
`define RST_LINKUP_ERR_THR        16'h051c
`define RST_EQ_TRAINING_TIMERS    16'h461b
`define RST_DSP_CONFIG_FOUR       16'h000f

// writable bit masks
`define WMASK_DSP_CONFIG_ONE      16'hff80
`define WMASK_FILTER_CONFIG_ONE   16'hf7ff
`define WMASK_FULL                16'hffff
`define WMASK_THRESHOLD           16'h7fff

// field positions
`define BIT_FILTER_BYPASS         7
`define BIT_STEADY_COEF_EN        10
`define BIT_LOOP_INPUT_SEL        8
`define MSB_SET1_THR              15
`define LSB_SET1_THR              12
`define MSB_LONG_COEF             7
`define LSB_LONG_COEF             6
`define MSB_SET0_THR              3
`define LSB_SET0_THR              0
`define MSB_START_GAIN            3
`define LSB_START_GAIN            0
`define MSB_MAX_GAIN              7
`define LSB_MAX_GAIN              4
`define MSB_MIN_GAIN              3
`define LSB_MIN_GAIN              0
`define MSB_THRESHOLD             14
`define LSB_THRESHOLD             0
`define MSB_TIMER_ONE             14
`define LSB_TIMER_ONE             12
`define MSB_TIMER_TWO             11
`define LSB_TIMER_TWO             6
`define MSB_TIMER_THREE           5
`define LSB_TIMER_THREE           3
`define MSB_TIMER_FOUR            2
`define LSB_TIMER_FOUR            0

`endif

// ### hdl/phy_dsp_tuning_registers.v
// receive dsp tuning register bank with its steering logic
// assumes a classic wishbone master on clk_i and datapath inputs on clk_i
//
// Functional notes
// - filter-bypass bit switches internal filter off during the training phase.
// - steady coefficient enable applies filter coefficient in steady state; resets zero.
// - upper nibble threshold activates short-cable coefficient set one; reset 1011.
// - lowest nibble threshold activates short-cable coefficient set zero; reset 1011.
// - two-bit long-cable coefficient field, bits 7:6, resets to 10.
// - bit 8 selects gain correction loop input type; resets to one.
// - gain loop starts from start index field; resets to 011.
// - gain index never exceeds max field, bits 7:4; reset 0000.
// - gain index kept at or above min field unless min exceeds max, bits 3:0; reset 1111.
// - at 100M leave steady state for recovery when error exceeds bad threshold.
// - at 100M timing loop judges quality against first good threshold.
// - at 100M link-up qualified against second good threshold.
// - state machine timing uses three-bit first training timer, reset 100.
// - timing loop uses six-bit second training timer, reset 011000.
// - gain loop uses third and fourth training timers, each reset 011.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "phy_dsp_tuning_defines.vh"

module phy_dsp_tuning_registers
(
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [11:0] adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // datapath status
    input  wire        speed_100_i,
    input  wire        training_phase_i,
    input  wire        steady_state_i,
    input  wire [3:0]  cable_metric_i,
    input  wire [14:0] error_measure_i,
    input  wire        gain_load_i,
    input  wire        gain_step_i,
    input  wire [3:0]  gain_request_i,
    // datapath controls
    output reg         filter_bypass_o,
    output reg         steady_coef_apply_o,
    output reg         short_set1_active_o,
    output reg         short_set0_active_o,
    output reg  [1:0]  long_coef_o,
    output reg         loop_input_sel_o,
    output reg  [3:0]  gain_index_o,
    output reg         recovery_request_o,
    output reg         timing_good_o,
    output reg         linkup_good_o,
    output reg  [2:0]  state_timer_o,
    output reg  [5:0]  timing_timer_o,
    output reg  [2:0]  gain_timer_a_o,
    output reg  [2:0]  gain_timer_b_o
);

    reg  [15:0] dsp_config_one;
    reg  [15:0] filter_config_one;
    reg  [15:0] filter_config_two;
    reg  [15:0] dsp_config_two;
    reg  [15:0] dsp_config_three;
    reg  [15:0] feedback_equalizer_control;
    reg  [15:0] gain_bandwidth_control;
    reg  [15:0] recovery_error_threshold;
    reg  [15:0] timing_loop_error_threshold;
    reg  [15:0] linkup_error_threshold;
    reg  [15:0] equalizer_training_timers;
    reg  [15:0] dsp_config_four;

    wire [8:0]  index = adr_i[10:2];
    wire        req   = cyc_i & stb_i & ~ack_o;
    wire        wr    = req & we_i;

    reg  [15:0] next_rdata;
    reg  [3:0]  next_gain;

    // byte-lane merge; only writable bits take new data
    function [15:0] merge;
        input [15:0] old;
        input [15:0] wdata;
        input [1:0]  lanes;
        input [15:0] wmask;
        reg   [15:0] lane_mask;
        begin
            lane_mask = {{8{lanes[1]}}, {8{lanes[0]}}} & wmask;
            merge     = (old & ~lane_mask) | (wdata & lane_mask);
        end
    endfunction

    // limit a gain index; upper limit checked last so it wins on crossed limits
    function [3:0] clamp;
        input [3:0] value;
        input [3:0] lo;
        input [3:0] hi;
        reg   [3:0] tmp;
        begin
            if (value < lo)
            begin
                tmp = lo;
            end
            else
            begin
                tmp = value;
            end
            if (tmp > hi)
            begin
                clamp = hi;
            end
            else
            begin
                clamp = tmp;
            end
        end
    endfunction

    // read mux; unmapped indices read zero
    always @*
    begin
        case (index)
            `IDX_DSP_CONFIG_ONE:      next_rdata = dsp_config_one;
            `IDX_FILTER_CONFIG_ONE:   next_rdata = filter_config_one;
            `IDX_FILTER_CONFIG_TWO:   next_rdata = filter_config_two;
            `IDX_DSP_CONFIG_TWO:      next_rdata = dsp_config_two;
            `IDX_DSP_CONFIG_THREE:    next_rdata = dsp_config_three;
            `IDX_FEEDBACK_EQ_CONTROL: next_rdata = feedback_equalizer_control;
            `IDX_GAIN_BW_CONTROL:     next_rdata = gain_bandwidth_control;
            `IDX_RECOVERY_ERR_THR:    next_rdata = recovery_error_threshold;
            `IDX_TIMING_LOOP_ERR_THR: next_rdata = timing_loop_error_threshold;
            `IDX_LINKUP_ERR_THR:      next_rdata = linkup_error_threshold;
            `IDX_EQ_TRAINING_TIMERS:  next_rdata = equalizer_training_timers;
            `IDX_DSP_CONFIG_FOUR:     next_rdata = dsp_config_four;
            default:                  next_rdata = 16'h0000;
        endcase
    end

    // bus slave: one wait state, ack for every address so the bus never hangs while ce_i is high
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            ack_o <= req;
            if (req & ~we_i)
                dat_o <= {16'h0000, next_rdata};
        end
    end

    // register file; reserved rw bits are stored so read-modify-write keeps them
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            dsp_config_one              <= `RST_DSP_CONFIG_ONE;
            filter_config_one           <= `RST_FILTER_CONFIG_ONE;
            filter_config_two           <= `RST_FILTER_CONFIG_TWO;
            dsp_config_two              <= `RST_DSP_CONFIG_TWO;
            dsp_config_three            <= `RST_DSP_CONFIG_THREE;
            feedback_equalizer_control  <= `RST_FEEDBACK_EQ_CONTROL;
            gain_bandwidth_control      <= `RST_GAIN_BW_CONTROL;
            recovery_error_threshold    <= `RST_RECOVERY_ERR_THR;
            timing_loop_error_threshold <= `RST_TIMING_LOOP_ERR_THR;
            linkup_error_threshold      <= `RST_LINKUP_ERR_THR;
            equalizer_training_timers   <= `RST_EQ_TRAINING_TIMERS;
            dsp_config_four             <= `RST_DSP_CONFIG_FOUR;
        end
        else if (ce_i && wr)
        begin
            case (index)
                `IDX_DSP_CONFIG_ONE:
                    dsp_config_one <= merge(dsp_config_one, dat_i[15:0], sel_i[1:0],
                                            `WMASK_DSP_CONFIG_ONE);
                `IDX_FILTER_CONFIG_ONE:
                    filter_config_one <= merge(filter_config_one, dat_i[15:0], sel_i[1:0],
                                               `WMASK_FILTER_CONFIG_ONE);
                `IDX_FILTER_CONFIG_TWO:
                    filter_config_two <= merge(filter_config_two, dat_i[15:0], sel_i[1:0],
                                               `WMASK_FULL);
                `IDX_DSP_CONFIG_TWO:
                    dsp_config_two <= merge(dsp_config_two, dat_i[15:0], sel_i[1:0],
                                            `WMASK_FULL);
                `IDX_DSP_CONFIG_THREE:
                    dsp_config_three <= merge(dsp_config_three, dat_i[15:0], sel_i[1:0],
                                              `WMASK_FULL);
                `IDX_FEEDBACK_EQ_CONTROL:
                    feedback_equalizer_control <= merge(feedback_equalizer_control,
                                                        dat_i[15:0], sel_i[1:0], `WMASK_FULL);
                `IDX_GAIN_BW_CONTROL:
                    gain_bandwidth_control <= merge(gain_bandwidth_control, dat_i[15:0],
                                                    sel_i[1:0], `WMASK_FULL);
                // bit 15 of the thresholds is read-only zero
                `IDX_RECOVERY_ERR_THR:
                    recovery_error_threshold <= merge(recovery_error_threshold, dat_i[15:0],
                                                      sel_i[1:0], `WMASK_THRESHOLD);
                `IDX_TIMING_LOOP_ERR_THR:
                    timing_loop_error_threshold <= merge(timing_loop_error_threshold,
                                                         dat_i[15:0], sel_i[1:0],
                                                         `WMASK_THRESHOLD);
                `IDX_LINKUP_ERR_THR:
                    linkup_error_threshold <= merge(linkup_error_threshold, dat_i[15:0],
                                                    sel_i[1:0], `WMASK_THRESHOLD);
                `IDX_EQ_TRAINING_TIMERS:
                    equalizer_training_timers <= merge(equalizer_training_timers, dat_i[15:0],
                                                       sel_i[1:0], `WMASK_FULL);
                `IDX_DSP_CONFIG_FOUR:
                    dsp_config_four <= merge(dsp_config_four, dat_i[15:0], sel_i[1:0],
                                             `WMASK_FULL);
                default:
                    dsp_config_four <= dsp_config_four;
            endcase
        end
    end

    // gain index source: load start value, or take the loop's request
    always @*
    begin
        if (gain_load_i)
        begin
            next_gain = dsp_config_three[`MSB_START_GAIN:`LSB_START_GAIN];
        end
        else if (gain_step_i)
        begin
            next_gain = gain_request_i;
        end
        else
        begin
            next_gain = gain_index_o;
        end
    end

    // crossed limits: max wins, so the reset limits pin the index at zero
    // limitation: the index only moves on load, step or a write that changes the limits
    // thresholds compare 15 bits; bit 15 is never stored
    // trade-off: one cycle of latency buys glitch-free steering outputs
    // steering outputs, all registered one cycle behind their causes
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            filter_bypass_o     <= 1'b0;
            steady_coef_apply_o <= 1'b0;
            short_set1_active_o <= 1'b0;
            short_set0_active_o <= 1'b0;
            long_coef_o         <= 2'b00;
            loop_input_sel_o    <= 1'b0;
            gain_index_o        <= 4'h0;
            recovery_request_o  <= 1'b0;
            timing_good_o       <= 1'b0;
            linkup_good_o       <= 1'b0;
            state_timer_o       <= 3'h0;
            timing_timer_o      <= 6'h00;
            gain_timer_a_o      <= 3'h0;
            gain_timer_b_o      <= 3'h0;
        end
        else if (ce_i)
        begin
            filter_bypass_o     <= dsp_config_one[`BIT_FILTER_BYPASS]
                                   & training_phase_i;
            steady_coef_apply_o <= filter_config_one[`BIT_STEADY_COEF_EN]
                                   & steady_state_i;
            short_set1_active_o <= cable_metric_i
                                   >= filter_config_one[`MSB_SET1_THR:`LSB_SET1_THR];
            short_set0_active_o <= cable_metric_i
                                   >= filter_config_one[`MSB_SET0_THR:`LSB_SET0_THR];
            long_coef_o         <= filter_config_one[`MSB_LONG_COEF:`LSB_LONG_COEF];
            loop_input_sel_o    <= dsp_config_two[`BIT_LOOP_INPUT_SEL];
            gain_index_o        <= clamp(next_gain,
                                         dsp_config_four[`MSB_MIN_GAIN:`LSB_MIN_GAIN],
                                         dsp_config_four[`MSB_MAX_GAIN:`LSB_MAX_GAIN]);
            // error comparisons only mean something at 100M
            recovery_request_o  <= speed_100_i & steady_state_i
                                   & (error_measure_i
                                      > recovery_error_threshold[`MSB_THRESHOLD:`LSB_THRESHOLD]);
            timing_good_o       <= speed_100_i
                                   & (error_measure_i
                                      <= timing_loop_error_threshold[`MSB_THRESHOLD:`LSB_THRESHOLD]);
            linkup_good_o       <= speed_100_i
                                   & (error_measure_i
                                      <= linkup_error_threshold[`MSB_THRESHOLD:`LSB_THRESHOLD]);
            state_timer_o       <= equalizer_training_timers[`MSB_TIMER_ONE:`LSB_TIMER_ONE];
            timing_timer_o      <= equalizer_training_timers[`MSB_TIMER_TWO:`LSB_TIMER_TWO];
            gain_timer_a_o      <= equalizer_training_timers[`MSB_TIMER_THREE:`LSB_TIMER_THREE];
            gain_timer_b_o      <= equalizer_training_timers[`MSB_TIMER_FOUR:`LSB_TIMER_FOUR];
        end
    end

endmodule

// ### tb/phy_dsp_tuning_properties.sv
// port-level checker for the dsp tuning register bank
// assumes one clock domain; bound to every instance of the bank by name
`timescale 1ns/10ps
module phy_dsp_tuning_properties
(
    input wire        clk_i,
    input wire        rst_i,
    input wire        ce_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        ack_o,
    input wire        training_phase_i,
    input wire        filter_bypass_o,
    input wire        steady_state_i,
    input wire        steady_coef_apply_o,
    input wire        speed_100_i,
    input wire [14:0] error_measure_i,
    input wire        recovery_request_o,
    input wire        timing_good_o,
    input wire        linkup_good_o,
    input wire [3:0]  gain_index_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o && ce_i |=> ack_o)
        else $error("request not answered in the next cycle");
    AST_ACK_PULSE: assert property (ack_o && ce_i |=> !ack_o)
        else $error("ack held longer than one cycle");
    AST_ACK_CAUSE: assert property (ack_o && $past(ce_i) |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    AST_BYPASS: assert property ($past(ce_i) && filter_bypass_o |-> $past(training_phase_i))
        else $error("filter bypass outside training");
    AST_COEF: assert property ($past(ce_i) && steady_coef_apply_o |-> $past(steady_state_i))
        else $error("coefficient applied outside steady state");
    AST_RECOVERY: assert property ($past(ce_i) && recovery_request_o |->
        $past(speed_100_i && steady_state_i) && $past(error_measure_i) != 15'h0)
        else $error("recovery request without cause");
    AST_TIMING_GOOD: assert property ($past(ce_i) && timing_good_o |-> $past(speed_100_i))
        else $error("timing good outside 100M");
    AST_LINKUP_GOOD: assert property ($past(ce_i) && linkup_good_o |-> $past(speed_100_i))
        else $error("link-up good outside 100M");
    // a frozen enable must hold bus answer and gain state alike
    AST_FREEZE: assert property (!ce_i |=> $stable(ack_o) && $stable(gain_index_o))
        else $error("state moved while clock enable low");

    cover property (recovery_request_o);
    cover property (filter_bypass_o && steady_coef_apply_o);
    cover property (linkup_good_o && timing_good_o);
endmodule

bind phy_dsp_tuning_registers phy_dsp_tuning_properties u_props (.*);

// ### tb/tb_top.sv
// self-checking bench for the dsp tuning register bank
// assumes the bank answers each wishbone request one cycle after taking it
`timescale 1ns/10ps
module tb_top;
    reg         clk_i, rst_i, ce_i, cyc_i, stb_i, we_i;
    reg  [11:0] adr_i;
    reg  [3:0]  sel_i, cable_metric_i, gain_request_i;
    reg  [31:0] dat_i;
    reg         speed_100_i, training_phase_i, steady_state_i, gain_load_i, gain_step_i;
    reg  [14:0] error_measure_i;
    wire [31:0] dat_o;
    wire        ack_o, filter_bypass_o, steady_coef_apply_o, short_set1_active_o;
    wire        short_set0_active_o, loop_input_sel_o, recovery_request_o;
    wire        timing_good_o, linkup_good_o;
    wire [1:0]  long_coef_o;
    wire [3:0]  gain_index_o;
    wire [2:0]  state_timer_o, gain_timer_a_o, gain_timer_b_o;
    wire [5:0]  timing_timer_o;
    integer     i, cycles, err_total, total_checks;
    reg  [8:0]  idx;
    reg  [15:0] rv, wv, ev, rd;
    reg  [56:0] rows [0:12];

    phy_dsp_tuning_registers u_dut (.*);

    always #12.5 clk_i = ~clk_i;

    // generous ceiling: the run needs well under a thousand cycles
    always @(posedge clk_i)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            err_total = err_total + 1;
            conclude;
        end
    end

    task conclude;
    begin
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask

    task chk(input [8*12:1] what, input [15:0] exp, input [15:0] got);
    begin
        total_checks = total_checks + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("[FAIL] %0s expected %h seen %h", what, exp, got);
        end
    end
    endtask

    task wb(input w, input [8:0] ix, input [15:0] wd, input [3:0] sl, output [15:0] q);
        integer n;
    begin
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {1'b0, ix, 2'b00};
        sel_i <= sl;
        dat_i <= {16'h0000, wd};
        n = 0;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n = n + 1;
        end
        if (n == 20)
            err_total = err_total + 1;
        q = dat_o[15:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    end
    endtask

    // outputs follow inputs one enabled cycle late, so two edges suffice
    task dp(input tr, input st, input sp, input [3:0] m, input [14:0] e);
    begin
        @(posedge clk_i);
        training_phase_i <= tr;
        steady_state_i <= st;
        speed_100_i <= sp;
        cable_metric_i <= m;
        error_measure_i <= e;
        repeat (2) @(posedge clk_i);
        #1;
    end
    endtask

    task gain(input ld, input sp, input [3:0] rq);
    begin
        @(posedge clk_i);
        gain_load_i <= ld;
        gain_step_i <= sp;
        gain_request_i <= rq;
        @(posedge clk_i);
        gain_load_i <= 1'b0;
        gain_step_i <= 1'b0;
        @(posedge clk_i);
        #1;
    end
    endtask

    initial
    begin
        {clk_i, ce_i, rst_i, cyc_i, stb_i, we_i} = 6'b011000;
        {adr_i, sel_i, dat_i, gain_request_i, cable_metric_i} = 56'h0;
        {speed_100_i, training_phase_i, steady_state_i, gain_load_i, gain_step_i} = 5'h0;
        error_measure_i = 15'h0000;
        {cycles, err_total, total_checks} = 96'h0;
        rows[0] = {9'h101, 16'h2000, 16'hffff, 16'hff80};
        rows[1] = {9'h106, 16'hb0bb, 16'h5c43, 16'h5443};
        rows[2] = {9'h107, 16'h0605, 16'ha5a5, 16'ha5a5};
        rows[3] = {9'h10f, 16'h0300, 16'h0000, 16'h0000};
        rows[4] = {9'h111, 16'h6003, 16'h0005, 16'h0005};
        rows[5] = {9'h114, 16'h400a, 16'h5a5a, 16'h5a5a};
        rows[6] = {9'h116, 16'h014a, 16'h1234, 16'h1234};
        rows[7] = {9'h121, 16'h199a, 16'h8100, 16'h0100};
        rows[8] = {9'h122, 16'h1027, 16'h8080, 16'h0080};
        rows[9] = {9'h123, 16'h051c, 16'h0040, 16'h0040};
        rows[10] = {9'h126, 16'h461b, 16'h3a5c, 16'h3a5c};
        rows[11] = {9'h129, 16'h000f, 16'h00a3, 16'h00a3};
        rows[12] = {9'h130, 16'h0000, 16'hffff, 16'h0000};
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        dp(1'b0, 1'b0, 1'b0, 4'h0, 15'h0);
        chk("long coef", 16'h2, long_coef_o);
        chk("loop input", 16'h1, loop_input_sel_o);
        chk("timers", 16'h461b, {1'b0, state_timer_o, timing_timer_o, gain_timer_a_o,
            gain_timer_b_o});
        for (i = 0; i < 13; i = i + 1)
        begin
            {idx, rv, wv, ev} = rows[i];
            wb(1'b0, idx, 16'h0, 4'h3, rd);
            chk("reset value", rv, rd);
            wb(1'b1, idx, wv, 4'h3, rd);
            wb(1'b0, idx, 16'h0, 4'h3, rd);
            chk("readback", ev, rd);
        end
        wb(1'b1, 9'h107, 16'hffff, 4'h1, rd);
        wb(1'b0, 9'h107, 16'h0, 4'h3, rd);
        chk("lane write", 16'ha5ff, rd);
        dp(1'b1, 1'b1, 1'b0, 4'h4, 15'h0);
        chk("bypass on", 16'h1, filter_bypass_o);
        chk("coef on", 16'h1, steady_coef_apply_o);
        chk("set1 low", 16'h0, short_set1_active_o);
        chk("set0 high", 16'h1, short_set0_active_o);
        chk("long coef", 16'h1, long_coef_o);
        chk("loop input", 16'h0, loop_input_sel_o);
        chk("timers", 16'h3a5c, {1'b0, state_timer_o, timing_timer_o, gain_timer_a_o,
            gain_timer_b_o});
        chk("slow good", 16'h0, timing_good_o);
        dp(1'b0, 1'b0, 1'b1, 4'h5, 15'h0100);
        chk("bypass off", 16'h0, filter_bypass_o);
        chk("coef off", 16'h0, steady_coef_apply_o);
        chk("set1 high", 16'h1, short_set1_active_o);
        chk("recov idle", 16'h0, recovery_request_o);
        chk("timing bad", 16'h0, timing_good_o);
        dp(1'b0, 1'b1, 1'b1, 4'h2, 15'h0101);
        chk("set0 low", 16'h0, short_set0_active_o);
        chk("recov above", 16'h1, recovery_request_o);
        dp(1'b0, 1'b1, 1'b1, 4'h2, 15'h0100);
        chk("recov equal", 16'h0, recovery_request_o);
        dp(1'b0, 1'b1, 1'b1, 4'h2, 15'h0080);
        chk("timing edge", 16'h1, timing_good_o);
        chk("linkup bad", 16'h0, linkup_good_o);
        dp(1'b0, 1'b1, 1'b1, 4'h2, 15'h0040);
        chk("linkup edge", 16'h1, linkup_good_o);
        gain(1'b0, 1'b1, 4'hf);
        chk("gain max", 16'ha, gain_index_o);
        gain(1'b0, 1'b1, 4'h1);
        chk("gain min", 16'h3, gain_index_o);
        gain(1'b1, 1'b1, 4'h9);
        chk("gain start", 16'h5, gain_index_o);
        @(posedge clk_i);
        ce_i <= 1'b0;
        gain(1'b0, 1'b1, 4'h7);
        chk("gain frozen", 16'h5, gain_index_o);
        @(posedge clk_i);
        ce_i <= 1'b1;
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1;
        chk("reset ack", 16'h0, ack_o);
        chk("reset gain", 16'h0, gain_index_o);
        @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 9'h106, 16'h0, 4'h3, rd);
        chk("rereset", 16'hb0bb, rd);
        conclude;
    end
endmodule
